// [core/apw_pkg.sv]
/*
 * apw_pkg: constants, register map and types for the angle pulse-width output.
 * assumes one 200 MHz clock and a 32-bit classic wishbone register bus.
 */
package apw_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned ANG_UPD_NS = 2000;
	localparam int unsigned ANG_UPD_CYC = ANG_UPD_NS / CLK_PERIOD_NS;

	// widths
	localparam int unsigned ANGLE_W = 16;
	localparam int unsigned CNT_W = 21;
	localparam int unsigned UPD_W = 9;

	// register indices; byte address is four times the index
	localparam logic [7:0] REG_IDX_OUT_CFG = 8'h25;
	localparam logic [7:0] REG_IDX_CLAMP_CFG = 8'h2a;
	localparam logic [7:0] REG_IDX_MON_CFG = 8'h2c;
	localparam logic [7:0] REG_IDX_STATUS = 8'h2d;
	localparam logic [7:0] REG_IDX_ANGLE = 8'h2e;

	// field positions
	localparam int unsigned OUT_EN_BIT = 24;
	localparam int unsigned OUT_CHSEL_BIT = 23;
	localparam int unsigned OUT_FREQ_LSB = 19;
	localparam int unsigned CLAMP_SEL_LSB = 23;
	localparam int unsigned MON_LIMIT_LSB = 0;
	localparam int unsigned STAT_MISMATCH_BIT = 0;
	localparam int unsigned STAT_LEVEL_BIT = 1;
	localparam int unsigned STAT_PIN_BIT = 2;

	// reset values
	localparam logic [3:0] FREQ_RST = 4'h0;
	localparam logic [2:0] CLAMP_RST = 3'h0;
	localparam logic [15:0] LIMIT_RST = 16'h00b6;

	// duty clamps in percent
	localparam int unsigned CLAMP_LO_BASE = 2;
	localparam int unsigned CLAMP_SEL_MAX = 6;
	localparam int unsigned PCT_FULL = 100;
	localparam int unsigned ANGLE_SCALE = 65536;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic en;
		logic chsel;
		logic [3:0] freq;
		logic [2:0] clamp;
		logic [15:0] limit;
		logic [ANGLE_W-1:0] pri;
		logic [ANGLE_W-1:0] sec;
		logic [UPD_W-1:0] upd;
		logic run;
		logic [CNT_W-1:0] phase;
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] high;
		logic [ANGLE_W-1:0] held;
		logic oe;
		logic mism;
		logic pin_s1;
		logic pin_s2;
	} apw_state_t;

	function automatic int unsigned carrier_hz(input logic [3:0] s);
		case (s)
			4'h0: carrier_hz = 125;
			4'h1: carrier_hz = 167;
			4'h2: carrier_hz = 250;
			4'h3: carrier_hz = 333;
			4'h4: carrier_hz = 500;
			4'h5: carrier_hz = 667;
			4'h6: carrier_hz = 800;
			4'h7: carrier_hz = 1000;
			4'h8: carrier_hz = 1333;
			4'h9: carrier_hz = 1600;
			4'ha: carrier_hz = 2000;
			4'hb: carrier_hz = 2667;
			4'hc: carrier_hz = 4000;
			4'hd: carrier_hz = 5333;
			4'he: carrier_hz = 8000;
			default: carrier_hz = 16000;
		endcase
	endfunction

	function automatic int unsigned clamp_lo(input logic [2:0] s);
		clamp_lo = (32'(s) > CLAMP_SEL_MAX) ? CLAMP_LO_BASE : CLAMP_LO_BASE + 32'(s);
	endfunction

endpackage

// [core/apw_pwm_out.sv]
/*
 * apw_pwm_out: free-running open-drain pwm whose duty encodes the angle,
 * with angle refresh, channel compare and a classic wishbone slave.
 * assumes angle inputs come from logic on mclk_i and an external pull-up on the pin.
 */
// Function
// - open-drain pulse output, duty proportional to selected channel angle.
// - output active only while enable bit 24 of location 0x25 is set.
// - bit 23 of location 0x25 selects primary or secondary channel.
// - each carrier period starts with a rising edge, rising to rising.
// - duty is high time from rising to falling edge over period.
// - bits 25:23 of location 0x2a pick clamps 2/98 to 8/92, 7 gives 2/98.
// - bits 22:19 of location 0x25 pick carrier 125 Hz to 16000 Hz.
// - angle captured at period start, held for the whole period.
// - carrier runs freely, not aligned to angle refresh.
// - angle registers refreshed with new value every update interval.
// - primary and secondary angles continuously compared for integrity.
// - angle update interval is 2 microseconds.
`timescale 1ns/1ps
module apw_pwm_out #(
	parameter int unsigned CLK_HZ = apw_pkg::CLK_HZ
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] angle_pri_i,
	input wire logic [15:0] angle_sec_i,
	input wire logic pwm_pin_i,
	output logic pwm_o,
	output logic pwm_oe_o,
	output logic mismatch_o
);

	apw_pkg::apw_state_t st_reg;
	apw_pkg::apw_state_t st_next;
	logic const_low_reg;

	function automatic logic [7:0] reg_addr(input logic [7:0] idx);
		reg_addr = 8'({idx, 2'b00});
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	function automatic logic [apw_pkg::CNT_W-1:0] period_cycles(input logic [3:0] s);
		period_cycles = apw_pkg::CNT_W'(CLK_HZ / apw_pkg::carrier_hz(s));
	endfunction

	function automatic logic [apw_pkg::CNT_W-1:0] high_cycles(input logic [apw_pkg::CNT_W-1:0] per,
		input logic [15:0] ang, input logic [2:0] cs);
		logic [63:0] lo;
		logic [63:0] span;
		logic [63:0] num;
		lo = 64'(apw_pkg::clamp_lo(cs));
		span = 64'(apw_pkg::PCT_FULL) - 64'(2) * lo;
		num = 64'(per) * (lo * 64'(apw_pkg::ANGLE_SCALE) + span * 64'(ang));
		high_cycles = apw_pkg::CNT_W'(num / (64'(apw_pkg::PCT_FULL) * 64'(apw_pkg::ANGLE_SCALE)));
	endfunction

	function automatic logic [15:0] ang_dist(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] d;
		d = a - b;
		ang_dist = d[15] ? 16'(-d) : d;
	endfunction

	function automatic logic [31:0] read_image(input apw_pkg::apw_state_t s, input logic [7:0] adr);
		read_image = 32'h0;
		if (adr == reg_addr(apw_pkg::REG_IDX_OUT_CFG)) begin
			read_image[apw_pkg::OUT_EN_BIT] = s.en;
			read_image[apw_pkg::OUT_CHSEL_BIT] = s.chsel;
			read_image[apw_pkg::OUT_FREQ_LSB +: 4] = s.freq;
		end else if (adr == reg_addr(apw_pkg::REG_IDX_CLAMP_CFG)) begin
			read_image[apw_pkg::CLAMP_SEL_LSB +: 3] = s.clamp;
		end else if (adr == reg_addr(apw_pkg::REG_IDX_MON_CFG)) begin
			read_image[apw_pkg::MON_LIMIT_LSB +: 16] = s.limit;
		end else if (adr == reg_addr(apw_pkg::REG_IDX_STATUS)) begin
			read_image[apw_pkg::STAT_MISMATCH_BIT] = s.mism;
			read_image[apw_pkg::STAT_LEVEL_BIT] = ~s.oe;
			read_image[apw_pkg::STAT_PIN_BIT] = s.pin_s2;
		end else if (adr == reg_addr(apw_pkg::REG_IDX_ANGLE)) begin
			read_image = {s.sec, s.pri};
		end
	endfunction

	logic [apw_pkg::CNT_W-1:0] phase_n;
	logic [apw_pkg::CNT_W-1:0] per_n;
	logic [15:0] ang_n;
	logic [31:0] wimg;

	always_comb begin
		st_next = st_reg;
		phase_n = '0;
		per_n = '0;
		ang_n = '0;
		wimg = 32'h0;

		// pin level readback through two flops
		st_next.pin_s1 = pwm_pin_i;
		st_next.pin_s2 = st_reg.pin_s1;

		// wishbone classic slave, one wait state, unmapped reads zero
		st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		st_next.rdat = 32'h0;
		if (wb_cyc_i && wb_stb_i && !st_reg.ack) begin
			st_next.rdat = read_image(st_reg, wb_adr_i);
			wimg = merge(read_image(st_reg, wb_adr_i), wb_dat_i, wb_sel_i);
			if (wb_we_i) begin
				if (wb_adr_i == reg_addr(apw_pkg::REG_IDX_OUT_CFG)) begin
					st_next.en = wimg[apw_pkg::OUT_EN_BIT];
					st_next.chsel = wimg[apw_pkg::OUT_CHSEL_BIT];
					st_next.freq = wimg[apw_pkg::OUT_FREQ_LSB +: 4];
				end else if (wb_adr_i == reg_addr(apw_pkg::REG_IDX_CLAMP_CFG)) begin
					st_next.clamp = wimg[apw_pkg::CLAMP_SEL_LSB +: 3];
				end else if (wb_adr_i == reg_addr(apw_pkg::REG_IDX_MON_CFG)) begin
					st_next.limit = wimg[apw_pkg::MON_LIMIT_LSB +: 16];
				end
			end
		end

		// angle refresh every update interval
		if (32'(st_reg.upd) == apw_pkg::ANG_UPD_CYC - 1) begin
			st_next.upd = '0;
			st_next.pri = angle_pri_i;
			st_next.sec = angle_sec_i;
		end else begin
			st_next.upd = st_reg.upd + 1'b1;
		end

		// channel compare
		st_next.mism = ang_dist(st_reg.pri, st_reg.sec) > st_reg.limit;

		// free-running carrier, own counter
		if (!st_reg.en) begin
			st_next.run = 1'b0;
			st_next.oe = 1'b0;
			st_next.phase = '0;
		end else begin
			st_next.run = 1'b1;
			if (!st_reg.run || st_reg.phase == st_reg.period - 1'b1) begin
				phase_n = '0;
			end else begin
				phase_n = st_reg.phase + 1'b1;
			end
			st_next.phase = phase_n;
			if (phase_n == '0) begin
				per_n = period_cycles(st_reg.freq);
				ang_n = st_reg.chsel ? st_reg.sec : st_reg.pri;
				st_next.period = per_n;
				st_next.held = ang_n;
				st_next.high = high_cycles(per_n, ang_n, st_reg.clamp);
				st_next.oe = 1'b0;
			end else begin
				st_next.oe = !(phase_n < st_reg.high);
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '{ack: 1'b0, rdat: 32'h0, en: 1'b0, chsel: 1'b0, freq: apw_pkg::FREQ_RST,
				clamp: apw_pkg::CLAMP_RST, limit: apw_pkg::LIMIT_RST, pri: '0, sec: '0, upd: '0,
				run: 1'b0, phase: '0, period: '0, high: '0, held: '0, oe: 1'b0, mism: 1'b0,
				pin_s1: 1'b0, pin_s2: 1'b0};
			const_low_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			const_low_reg <= 1'b0;
		end
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.rdat;
	assign pwm_oe_o = st_reg.oe;
	assign pwm_o = const_low_reg;
	assign mismatch_o = st_reg.mism;

	// checks
	localparam int UPD_LAST = int'(apw_pkg::ANG_UPD_CYC) - 1;
	localparam int UPD_GAP = UPD_LAST - 1;

	property p_disabled_released;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!st_reg.en |=> !pwm_oe_o;
	endproperty
	a_disabled_released: assert property (p_disabled_released) else $error("output driven while disabled");

	property p_period_starts_high;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase == '0 |-> !pwm_oe_o;
	endproperty
	a_period_starts_high: assert property (p_period_starts_high) else $error("period does not start high");

	property p_high_then_low;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && $past(st_reg.run) |-> (pwm_oe_o == !(st_reg.phase < st_reg.high));
	endproperty
	a_high_then_low: assert property (p_high_then_low) else $error("level disagrees with high time");

	property p_angle_held;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase != '0 |-> $stable(st_reg.held);
	endproperty
	a_angle_held: assert property (p_angle_held) else $error("angle changed inside a period");

	property p_channel_pick;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase == '0 |->
			st_reg.held == ($past(st_reg.chsel) ? $past(st_reg.sec) : $past(st_reg.pri));
	endproperty
	a_channel_pick: assert property (p_channel_pick) else $error("wrong channel captured");

	property p_period_value;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase == '0 |-> st_reg.period == period_cycles($past(st_reg.freq));
	endproperty
	a_period_value: assert property (p_period_value) else $error("carrier period mismatch");

	property p_clamp_range;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase == '0 |->
			64'(st_reg.high) * 64'(apw_pkg::PCT_FULL) >=
				64'(st_reg.period) * 64'(apw_pkg::clamp_lo($past(st_reg.clamp))) - 64'(apw_pkg::PCT_FULL) &&
			64'(st_reg.high) * 64'(apw_pkg::PCT_FULL) <=
				64'(st_reg.period) * 64'(apw_pkg::PCT_FULL - apw_pkg::clamp_lo($past(st_reg.clamp)));
	endproperty
	a_clamp_range: assert property (p_clamp_range) else $error("high time outside clamps");

	sequence s_refresh_tick;
		32'(st_reg.upd) == UPD_LAST ##1 st_reg.upd == '0;
	endsequence

	property p_refresh;
		@(posedge mclk_i) disable iff (!rst_n_i)
		s_refresh_tick |-> st_reg.pri == $past(angle_pri_i) && st_reg.sec == $past(angle_sec_i)
			##1 (st_reg.upd == 9'h001) [*1];
	endproperty
	a_refresh: assert property (p_refresh) else $error("angle refresh missed");

	property p_refresh_interval;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.upd == '0 |=> st_reg.upd != '0 ##[UPD_GAP:UPD_GAP] st_reg.upd != '0 ##1 st_reg.upd == '0;
	endproperty
	a_refresh_interval: assert property (p_refresh_interval) else $error("refresh interval wrong");

	property p_compare;
		@(posedge mclk_i) disable iff (!rst_n_i)
		##1 1'b1 |-> mismatch_o == (ang_dist($past(st_reg.pri), $past(st_reg.sec)) > $past(st_reg.limit));
	endproperty
	a_compare: assert property (p_compare) else $error("channel compare wrong");

	property p_ack_one_cycle;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack longer than one cycle");

	property p_ack_answers;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answers: assert property (p_ack_answers) else $error("request not answered next cycle");

	property p_ack_needs_req;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

	property p_rdat_idle_zero;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_rdat_idle_zero: assert property (p_rdat_idle_zero) else $error("read data not zero outside ack");

	sequence s_out_cfg_write;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf &&
			wb_adr_i == reg_addr(apw_pkg::REG_IDX_OUT_CFG);
	endsequence

	property p_out_cfg_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		s_out_cfg_write |=> st_reg.en == $past(wb_dat_i[apw_pkg::OUT_EN_BIT]) &&
			st_reg.chsel == $past(wb_dat_i[apw_pkg::OUT_CHSEL_BIT]) &&
			st_reg.freq == $past(wb_dat_i[apw_pkg::OUT_FREQ_LSB +: 4]);
	endproperty
	a_out_cfg_write: assert property (p_out_cfg_write) else $error("output config write lost");

	sequence s_clamp_cfg_write;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf &&
			wb_adr_i == reg_addr(apw_pkg::REG_IDX_CLAMP_CFG);
	endsequence

	property p_clamp_cfg_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		s_clamp_cfg_write |=> st_reg.clamp == $past(wb_dat_i[apw_pkg::CLAMP_SEL_LSB +: 3]);
	endproperty
	a_clamp_cfg_write: assert property (p_clamp_cfg_write) else $error("clamp select write lost");

	property p_first_period;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.en && !st_reg.run |=> st_reg.run && st_reg.phase == '0 && !pwm_oe_o;
	endproperty
	a_first_period: assert property (p_first_period) else $error("first period not started high");

	property p_phase_wrap;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.en && st_reg.run && st_reg.phase == st_reg.period - 1'b1 |=> st_reg.phase == '0;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("period did not restart");

	property p_phase_step;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.en && st_reg.run && st_reg.phase != st_reg.period - 1'b1 |=>
			st_reg.phase == $past(st_reg.phase) + 1'b1;
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("carrier phase skipped");

	property p_low_stays;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.en && st_reg.run && pwm_oe_o && st_reg.phase != st_reg.period - 1'b1 |=> pwm_oe_o;
	endproperty
	a_low_stays: assert property (p_low_stays) else $error("second rise inside a period");

	property p_high_inside;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.run && st_reg.phase == '0 |-> st_reg.high != '0 && st_reg.high < st_reg.period;
	endproperty
	a_high_inside: assert property (p_high_inside) else $error("high time not inside period");

	property p_refresh_only;
		@(posedge mclk_i) disable iff (!rst_n_i)
		st_reg.upd != '0 |-> $stable(st_reg.pri) && $stable(st_reg.sec);
	endproperty
	a_refresh_only: assert property (p_refresh_only) else $error("angle changed between refreshes");

	property p_pin_sync;
		@(posedge mclk_i) disable iff (!rst_n_i)
		##2 1'b1 |-> st_reg.pin_s2 == $past(pwm_pin_i, 2);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin readback not two flops deep");

endmodule

// [dv/apw_mcu_model.sv]
/*
 * apw_mcu_model: receiver that times the edges of the pwm pin.
 * assumes the pin level is resolved by the bench, pull-up included.
 */
`timescale 1ns/1ps
module apw_mcu_model (
	input wire logic mclk_i,
	input wire logic pin_i,
	output int period_o,
	output int high_o,
	output int rises_o
);
	int cnt = 0;
	logic last = 1'b1;
	always @(posedge mclk_i) begin
		last <= pin_i;
		cnt <= cnt + 1;
		if (pin_i && !last) begin
			period_o <= cnt;
			cnt <= 1;
			rises_o <= rises_o + 1;
		end
		if (!pin_i && last) begin
			high_o <= cnt;
		end
	end
endmodule

// [dv/tb.sv]
/*
 * tb: register bus tests of the angle pwm output.
 * assumes a pull-up on the pin and the carrier scaled by CLK_HZ.
 */
`timescale 1ns/1ps
module tb;
	localparam int HZ = 2000000;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [15:0] pri = 16'h0000;
	logic [15:0] sec = 16'h0000;
	logic ack, pwm, oe, mism, pin;
	int err_count = 0;
	int check_count = 0;
	int cyc_cnt = 0;
	int r, n;
	int fhz[16] = '{125, 167, 250, 333, 500, 667, 800, 1000, 1333, 1600, 2000, 2667, 4000, 5333, 8000, 16000};
	// pull-up while released
	assign pin = oe ? pwm : 1'b1;
	apw_pwm_out #(.CLK_HZ(HZ)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.angle_pri_i(pri), .angle_sec_i(sec), .pwm_pin_i(pin), .pwm_o(pwm), .pwm_oe_o(oe), .mismatch_o(mism));
	apw_mcu_model u_mcu (.mclk_i(mclk_i), .pin_i(pin), .period_o(), .high_o(), .rises_o());
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 90000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge mclk_i);
		while (ack !== 1'b1) @(posedge mclk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rises(input int k);
		r = u_mcu.rises_o + k;
		while (u_mcu.rises_o < r) @(posedge mclk_i);
	endtask
	// refresh settles, then two whole periods after the next start
	task automatic meas();
		repeat (401) @(posedge mclk_i);
		rises(3);
	endtask
	function automatic int eh(int p, int s, int a);
		int lo;
		lo = (s > 6) ? 2 : 2 + s;
		return int'((longint'(p) * (lo * 65536 + (100 - 2 * lo) * a)) / 6553600);
	endfunction
	function automatic logic [31:0] oc(logic e, logic c, logic [3:0] f);
		return {7'h00, e, c, f, 19'h00000};
	endfunction
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		bus(1'b0, 8'h94, 32'h0);
		chk(q, 32'h0, "out cfg reset");
		bus(1'b0, 8'ha8, 32'h0);
		chk(q, 32'h0, "clamp reset");
		bus(1'b0, 8'hb0, 32'h0);
		chk(q, 32'h00b6, "limit reset");
		bus(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0, "unmapped");
		pri <= 16'hffff;
		repeat (500) @(posedge mclk_i);
		chk(u_mcu.rises_o, 0, "edges while off");
		$display("test reset done");
		bus(1'b1, 8'h94, oc(1'b1, 1'b0, 4'hf));
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, 8'ha8, {6'h00, 3'(s), 23'h0});
			for (int a = 0; a < 2; a++) begin
				pri <= a ? 16'hffff : 16'h0000;
				meas();
				chk(u_mcu.high_o, eh(125, s, a ? 65535 : 0), "clamp high");
				chk(u_mcu.period_o, 125, "period");
			end
		end
		$display("test clamps done");
		pri <= 16'h2000;
		sec <= 16'hc000;
		for (int c = 0; c < 2; c++) begin
			bus(1'b1, 8'h94, oc(1'b1, 1'(c), 4'hf));
			meas();
			chk(u_mcu.high_o, eh(125, 7, c ? 32'hc000 : 32'h2000), "channel");
		end
		bus(1'b0, 8'hb8, 32'h0);
		chk(q, 32'hc0002000, "angle regs");
		chk(mism, 1'b1, "mismatch far");
		pri <= 16'hffa0;
		sec <= 16'h0056;
		// refresh, then one more edge for the registered compare
		repeat (402) @(posedge mclk_i);
		chk(mism, 1'b0, "mismatch at limit");
		sec <= 16'h0057;
		repeat (402) @(posedge mclk_i);
		bus(1'b0, 8'hb4, 32'h0);
		chk(q[0], 1'b1, "mismatch status");
		$display("test channels done");
		bus(1'b1, 8'h94, oc(1'b1, 1'b0, 4'hc));
		pri <= 16'hffff;
		meas();
		rises(1);
		pri <= 16'h0000;
		rises(1);
		chk(u_mcu.high_o, eh(500, 7, 65535), "held angle");
		rises(1);
		chk(u_mcu.high_o, eh(500, 7, 0), "next angle");
		$display("test capture done");
		// upper half of the table keeps the run short
		pri <= 16'h8000;
		for (int f = 8; f < 16; f++) begin
			bus(1'b1, 8'h94, oc(1'b1, 1'b0, 4'(f)));
			meas();
			chk(u_mcu.period_o, HZ / fhz[f], "carrier");
			chk(u_mcu.high_o, eh(HZ / fhz[f], 7, 32768), "mid duty");
		end
		$display("test carrier done");
		bus(1'b1, 8'h94, oc(1'b0, 1'b0, 4'hf));
		repeat (2) @(posedge mclk_i);
		n = 0;
		repeat (300) begin
			@(posedge mclk_i);
			if (oe !== 1'b0) n++;
		end
		chk(n, 0, "pulled while off");
		chk(pwm, 1'b0, "open-drain data");
		bus(1'b0, 8'hb4, 32'h0);
		chk(q, 32'h0000_0007, "status while off");
		bus(1'b1, 8'hb8, 32'hffff_ffff);
		bus(1'b0, 8'hb8, 32'h0);
		chk(q, 32'h0057_8000, "angle regs read-only");
		$display("test disable done");
		tally_and_finish();
	end
endmodule
